// *** verilog/i2c_engine_pkg.sv ***
// Shared constants for the two-wire master byte engine
package i2c_engine_pkg;
    localparam int unsigned CLOCK_HZ         = 125_000_000;
    localparam int unsigned RELOAD_WIDTH     = 9;
    localparam int unsigned BITS_PER_BYTE    = 8;
    localparam logic [3:0]  BIT_COUNT_RESET  = 4'h0;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;
    localparam logic [8:0]  RELOAD_RESET     = 9'h000;
    localparam int unsigned ACK_PERIODS      = 2;
    localparam logic [4:0]  TEN_BIT_PREFIX   = 5'h1e;
    localparam int unsigned CMD_RESTART_BIT  = 1;
    localparam int unsigned CMD_STOP_BIT     = 2;
    localparam int unsigned CMD_RECEIVE_BIT  = 3;
    localparam int unsigned CMD_ACK_BIT      = 4;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        ST_BIT_LOW  = 4'b0001,
        ST_BIT_HIGH = 4'b0011,
        ST_ACK_LOW  = 4'b0010,
        ST_ACK_HIGH = 4'b0110,
        ST_RS_LOW   = 4'b0111,
        ST_RS_HIGH  = 4'b0101,
        ST_RS_SDA   = 4'b0100,
        ST_SP_LOW   = 4'b1100,
        ST_SP_HIGH  = 4'b1101,
        ST_MA_LOW   = 4'b1111,
        ST_MA_HIGH  = 4'b1110
    } engine_state_e;

    // First byte of a 10-bit address; write direction on first send
    function automatic logic [7:0] ten_bit_first_byte(input logic [1:0] upper, input logic rd);
        ten_bit_first_byte = {TEN_BIT_PREFIX, upper, rd};
    endfunction : ten_bit_first_byte
endpackage : i2c_engine_pkg

// *** verilog/i2c_pin_sync.sv ***
// Two-flop synchroniser for the bus lines
`timescale 1ns/10ps
module i2c_pin_sync
    import i2c_engine_pkg::*;
#(
    parameter int unsigned WIDTH = 2
)(
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            meta_q <= '1;
            sync_q <= '1;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end
    assign o_sync = sync_q;
endmodule : i2c_pin_sync

// *** verilog/i2c_baud_gen.sv ***
// Baud period counter with reload
`timescale 1ns/10ps
module i2c_baud_gen
    import i2c_engine_pkg::*;
#(
    parameter int unsigned WIDTH = RELOAD_WIDTH
)(
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_reload,
    output logic                  o_expire
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic             expire_d;

    always_comb
    begin
        expire_d = 1'b0;
        count_d  = count_q;
        if (i_load)
            count_d = i_reload;
        else if (count_q == '0)
        begin
            expire_d = 1'b1;
            count_d  = i_reload;
        end
        else
            count_d = count_q - 1'b1;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
            count_q <= '0;
        else
            count_q <= count_d;
    end
    assign o_expire = expire_d & ~i_load;
endmodule : i2c_baud_gen

// *** verilog/i2c_master_byte_engine.sv ***
// Master byte engine: transmit, receive, acknowledge, stop, repeated start
// Notes on behaviour
// - After eighth transmitted bit clear buffer-full, release data, give ninth clock.
// - Ninth clock falling edge captures acknowledge: 0 acked, 1 not acked.
// - After ninth clock raise event pulse and idle until next transmit or command write.
// - Buffer-full sets on transmit write and clears after eight bits shift.
// - Transmit write while busy is dropped and sets write collision until cleared.
// - Command writes are ignored while any master operation is running.
// - Receive command clocks in eight bits, sampling data before falling edges.
// - After eighth received bit clear command, load buffer, set full, pulse event.
// - Reading the receive buffer clears receive-buffer-full.
// - Byte completing while full sets overflow and is discarded.
// - Overflow does not block reception; later bytes load normally.
// - Acknowledge command sends one bit with polarity from ack data select.
// - Acknowledge ends after two baud periods, clears command, pulses event.
// - Stop sends stop, sets stop-seen, clears start-seen, clears command, events.
// - Repeated start: clock low, data released, clock up, hold, data low.
// - Repeated start end: start-seen set, stop-seen clear, clock low, event.
// - Slave may stretch clock; baud count restarts only after clock released.
// - Ack data select 1 sends not-acknowledge, 0 sends acknowledge.
// - Clock released and seen high reloads baud counter for one period.
`timescale 1ns/10ps
module i2c_master_byte_engine
    import i2c_engine_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_reset_n,
    input  wire logic [8:0] i_baud_reload,
    input  wire logic       i_tx_write,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_cmd_write,
    input  wire logic [4:0] i_cmd_bits,
    input  wire logic       i_ack_data_select,
    input  wire logic       i_rx_read,
    input  wire logic       i_collision_clear,
    input  wire logic       i_overflow_clear,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_scl_out,
    output logic            o_scl_oe,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    output logic [4:0]      o_command,
    output logic            o_tx_buffer_full,
    output logic            o_ack_received_status,
    output logic            o_write_collision_flag,
    output logic [7:0]      o_receive_buffer_reg,
    output logic            o_rx_buffer_full,
    output logic            o_receive_overflow_flag,
    output logic            o_start_seen,
    output logic            o_stop_seen,
    output logic            o_master_event_irq
);
    engine_state_e state_q, state_d;
    logic [4:0] cmd_q, cmd_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] rcv_q, rcv_d;
    logic [3:0] bits_q, bits_d;
    logic [1:0] periods_q, periods_d;
    logic       rx_mode_q, rx_mode_d;
    logic       scl_low_q, scl_low_d;
    logic       sda_low_q, sda_low_d;
    logic       tbf_q, tbf_d, ack_q, ack_d, col_q, col_d;
    logic       rbf_q, rbf_d, ov_q, ov_d;
    logic       start_q, start_d, stop_q, stop_d;
    logic       irq_q, irq_d;
    logic       sample_q, sample_d;
    logic       load;
    logic       expire;
    logic       busy;
    logic [1:0] pins_sync;
    logic       scl_in, sda_in;
    logic       scl_in_q;

    i2c_pin_sync #(.WIDTH(2)) u_sync (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_async   ({i_scl, i_sda}),
        .o_sync    (pins_sync)
    );
    assign scl_in = pins_sync[1];
    assign sda_in = pins_sync[0];

    // Reload on each released-and-high transition of the clock line
    assign load = (state_q == ST_IDLE) || (!scl_low_q && scl_in && !scl_in_q);

    i2c_baud_gen #(.WIDTH(RELOAD_WIDTH)) u_baud (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_load    (load),
        .i_reload  (i_baud_reload),
        .o_expire  (expire)
    );

    assign busy = (state_q != ST_IDLE);

    always_comb
    begin
        state_d   = state_q;
        cmd_d     = cmd_q;
        shift_d   = shift_q;
        rcv_d     = rcv_q;
        bits_d    = bits_q;
        periods_d = periods_q;
        rx_mode_d = rx_mode_q;
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        tbf_d     = tbf_q;
        ack_d     = ack_q;
        col_d     = col_q;
        rbf_d     = rbf_q;
        ov_d      = ov_q;
        start_d   = start_q;
        stop_d    = stop_q;
        irq_d     = 1'b0;
        sample_d  = sample_q;
        if (i_rx_read)
            rbf_d = 1'b0;
        if (i_collision_clear)
            col_d = 1'b0;
        if (i_overflow_clear)
            ov_d = 1'b0;
        // Clock held low by slave: data sample keeps its value in high phases
        if (!scl_low_q && !scl_in)
            sample_d = sample_q;
        else if (!scl_low_q)
            sample_d = sda_in;
        unique case (state_q)
            ST_IDLE:
            begin
                if (i_tx_write)
                begin
                    shift_d   = i_tx_data;
                    tbf_d     = 1'b1;
                    bits_d    = BIT_COUNT_RESET;
                    rx_mode_d = 1'b0;
                    scl_low_d = 1'b1;
                    sda_low_d = ~i_tx_data[7];
                    state_d   = ST_BIT_LOW;
                end
                else if (i_cmd_write && i_cmd_bits[CMD_RECEIVE_BIT])
                begin
                    cmd_d     = i_cmd_bits;
                    bits_d    = BIT_COUNT_RESET;
                    rx_mode_d = 1'b1;
                    scl_low_d = 1'b1;
                    sda_low_d = 1'b0;
                    state_d   = ST_BIT_LOW;
                end
                else if (i_cmd_write && i_cmd_bits[CMD_ACK_BIT])
                begin
                    cmd_d     = i_cmd_bits;
                    scl_low_d = 1'b1;
                    sda_low_d = ~i_ack_data_select;
                    periods_d = '0;
                    state_d   = ST_MA_LOW;
                end
                else if (i_cmd_write && i_cmd_bits[CMD_STOP_BIT])
                begin
                    cmd_d     = i_cmd_bits;
                    scl_low_d = 1'b1;
                    sda_low_d = 1'b1;
                    state_d   = ST_SP_LOW;
                end
                else if (i_cmd_write && i_cmd_bits[CMD_RESTART_BIT])
                begin
                    cmd_d     = i_cmd_bits;
                    scl_low_d = 1'b1;
                    sda_low_d = 1'b0;
                    state_d   = ST_RS_LOW;
                end
            end
            ST_BIT_LOW:
            begin
                if (expire)
                begin
                    scl_low_d = 1'b0;
                    state_d   = ST_BIT_HIGH;
                end
            end
            ST_BIT_HIGH:
            begin
                if (expire && scl_in)
                begin
                    scl_low_d = 1'b1;
                    bits_d    = bits_q + 4'h1;
                    if (rx_mode_q)
                        shift_d = {shift_q[6:0], sample_q};
                    else
                        shift_d = {shift_q[6:0], 1'b0};
                    if (bits_q == 4'(BITS_PER_BYTE - 1))
                    begin
                        if (rx_mode_q)
                        begin
                            cmd_d   = '0;
                            irq_d   = 1'b1;
                            state_d = ST_IDLE;
                            scl_low_d = 1'b1;
                            if (rbf_q && !i_rx_read)
                                ov_d = 1'b1;
                            else
                            begin
                                rcv_d = {shift_q[6:0], sample_q};
                                rbf_d = 1'b1;
                            end
                        end
                        else
                        begin
                            tbf_d     = 1'b0;
                            sda_low_d = 1'b0;
                            state_d   = ST_ACK_LOW;
                        end
                    end
                    else if (!rx_mode_q)
                        sda_low_d = ~shift_q[6];
                    state_d = (bits_q == 4'(BITS_PER_BYTE - 1)) ? state_d : ST_BIT_LOW;
                end
            end
            ST_ACK_LOW:
            begin
                if (expire)
                begin
                    scl_low_d = 1'b0;
                    state_d   = ST_ACK_HIGH;
                end
            end
            ST_ACK_HIGH:
            begin
                if (expire && scl_in)
                begin
                    ack_d     = sample_q;
                    scl_low_d = 1'b1;
                    irq_d     = 1'b1;
                    state_d   = ST_IDLE;
                end
            end
            ST_MA_LOW:
            begin
                if (expire)
                begin
                    scl_low_d = 1'b0;
                    periods_d = periods_q + 2'h1;
                    state_d   = ST_MA_HIGH;
                end
            end
            ST_MA_HIGH:
            begin
                if (expire && scl_in)
                begin
                    scl_low_d = 1'b1;
                    sda_low_d = 1'b0;
                    cmd_d     = '0;
                    periods_d = periods_q + 2'h1;
                    irq_d     = 1'b1;
                    state_d   = ST_IDLE;
                end
            end
            ST_SP_LOW:
            begin
                if (expire)
                begin
                    scl_low_d = 1'b0;
                    state_d   = ST_SP_HIGH;
                end
            end
            ST_SP_HIGH:
            begin
                if (expire && scl_in)
                begin
                    sda_low_d = 1'b0;
                    stop_d    = 1'b1;
                    start_d   = 1'b0;
                    cmd_d     = '0;
                    irq_d     = 1'b1;
                    state_d   = ST_IDLE;
                end
            end
            ST_RS_LOW:
            begin
                if (expire && sda_in)
                begin
                    scl_low_d = 1'b0;
                    state_d   = ST_RS_HIGH;
                end
            end
            ST_RS_HIGH:
            begin
                if (expire && scl_in && sda_in)
                begin
                    sda_low_d = 1'b1;
                    state_d   = ST_RS_SDA;
                end
            end
            ST_RS_SDA:
            begin
                if (expire)
                begin
                    scl_low_d = 1'b1;
                    start_d   = 1'b1;
                    stop_d    = 1'b0;
                    cmd_d     = '0;
                    irq_d     = 1'b1;
                    state_d   = ST_IDLE;
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
        // Writes during a running operation are dropped
        if (busy && i_tx_write)
            col_d = 1'b1;
        if (busy && i_cmd_write)
            cmd_d = (state_d == ST_IDLE) ? '0 : cmd_q;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            state_q   <= ST_IDLE;
            cmd_q     <= '0;
            shift_q   <= BYTE_RESET;
            rcv_q     <= BYTE_RESET;
            bits_q    <= BIT_COUNT_RESET;
            periods_q <= '0;
            rx_mode_q <= 1'b0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            tbf_q     <= 1'b0;
            ack_q     <= 1'b0;
            col_q     <= 1'b0;
            rbf_q     <= 1'b0;
            ov_q      <= 1'b0;
            start_q   <= 1'b0;
            stop_q    <= 1'b0;
            irq_q     <= 1'b0;
            sample_q  <= 1'b1;
            scl_in_q  <= 1'b1;
        end
        else
        begin
            state_q   <= state_d;
            cmd_q     <= cmd_d;
            shift_q   <= shift_d;
            rcv_q     <= rcv_d;
            bits_q    <= bits_d;
            periods_q <= periods_d;
            rx_mode_q <= rx_mode_d;
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
            tbf_q     <= tbf_d;
            ack_q     <= ack_d;
            col_q     <= col_d;
            rbf_q     <= rbf_d;
            ov_q      <= ov_d;
            start_q   <= start_d;
            stop_q    <= stop_d;
            irq_q     <= irq_d;
            sample_q  <= sample_d;
            scl_in_q  <= scl_in;
        end
    end

    assign o_scl_out               = 1'b0;
    assign o_scl_oe                = scl_low_q;
    assign o_sda_out               = 1'b0;
    assign o_sda_oe                = sda_low_q;
    assign o_command               = cmd_q;
    assign o_tx_buffer_full        = tbf_q;
    assign o_ack_received_status   = ack_q;
    assign o_write_collision_flag  = col_q;
    assign o_receive_buffer_reg    = rcv_q;
    assign o_rx_buffer_full        = rbf_q;
    assign o_receive_overflow_flag = ov_q;
    assign o_start_seen            = start_q;
    assign o_stop_seen             = stop_q;
    assign o_master_event_irq      = irq_q;

    a_collision_sets: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        busy && i_tx_write |=> o_write_collision_flag)
        else $error("collision flag not set");
    a_tbf_on_write: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        !busy && i_tx_write |=> o_tx_buffer_full && o_scl_oe)
        else $error("buffer full not set");
    a_cmd_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        busy && i_cmd_write && state_d != ST_IDLE |=> o_command == $past(cmd_q))
        else $error("command changed while busy");
    a_rbf_read: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_rx_read && state_q == ST_IDLE |=> !o_rx_buffer_full)
        else $error("read did not clear full");
    a_ov_sticky: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_receive_overflow_flag && !i_overflow_clear |=> o_receive_overflow_flag)
        else $error("overflow lost");
    a_irq_idle: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_master_event_irq |-> state_q == ST_IDLE && o_command == 5'h00)
        else $error("event while busy");
    a_ack_txdone: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        state_q == ST_ACK_LOW |-> !o_tx_buffer_full && !o_sda_oe)
        else $error("data not released for ack");
    a_stop_flags: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        state_q == ST_SP_HIGH && state_d == ST_IDLE |=> o_stop_seen && !o_start_seen)
        else $error("stop flags wrong");
    a_ack_periods: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        state_q == ST_MA_HIGH && state_d == ST_IDLE |=> periods_q == 2'(ACK_PERIODS))
        else $error("acknowledge not two periods");
endmodule : i2c_master_byte_engine

// *** dv/i2c_slave_model.sv ***
// Behavioural slave on the two-wire bus: listens, acknowledges, talks, stretches
`timescale 1ns/10ps
module i2c_slave_model (
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic [1:0] i_mode,
    input  wire logic       i_frame_start,
    input  wire logic       i_ack_n,
    input  wire logic [7:0] i_talk_byte,
    input  wire logic       i_stretch,
    output logic            o_scl_oe,
    output logic            o_sda_oe,
    output logic [7:0]      o_heard_byte,
    output logic            o_last_bit
);
    int         rises = 0;
    logic [7:0] shift = 8'h00;
    initial
    begin
        o_scl_oe     = 1'b0;
        o_sda_oe     = 1'b0;
        o_heard_byte = 8'h00;
        o_last_bit   = 1'b0;
    end
    // Mode 1 listens and acknowledges, mode 2 talks MSB first
    always @(posedge i_frame_start)
    begin
        rises    = 0;
        o_sda_oe = (i_mode == 2'h2) && !i_talk_byte[7];
    end
    always @(posedge i_scl)
    begin
        rises      = rises + 1;
        o_last_bit = i_sda;
        shift      = {shift[6:0], i_sda};
        if (rises == 8)
            o_heard_byte = shift;
    end
    always @(negedge i_scl)
    begin
        if (i_mode == 2'h1)
            o_sda_oe = (rises == 8) && !i_ack_n;
        else if (i_mode == 2'h2)
            o_sda_oe = (rises < 8) && !i_talk_byte[3'(7 - rises)];
        if (i_stretch && rises == 1)
        begin
            o_scl_oe = 1'b1;
            #200;
            o_scl_oe = 1'b0;
        end
    end
endmodule : i2c_slave_model

// *** dv/tb_top.sv ***
// Self-checking bench for the master byte engine
`timescale 1ns/10ps
module tb_top;
    import i2c_engine_pkg::*;
    typedef struct {
        logic [2:0] op;
        logic [7:0] data;
        logic       ack_n;
        logic       ack_sel;
        logic       stretch;
    } op_row_s;
    logic       i_clock = 1'b0;
    logic       i_reset_n = 1'b0;
    logic       tx_write = 1'b0, cmd_write = 1'b0, ack_sel = 1'b0, rx_read = 1'b0;
    logic       coll_clr = 1'b0, ovf_clr = 1'b0, frame_start = 1'b0, s_ack_n = 1'b0;
    logic       stretch = 1'b0;
    logic [7:0] tx_data = 8'h00, talk = 8'h00;
    logic [4:0] cmd_bits = 5'h00;
    logic [1:0] mode = 2'h0;
    logic       m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe, tx_buffer_full, ack_st, coll, rx_buffer_full, ovf;
    logic       start_seen, stop_seen, irq, last_bit, scl_out, sda_out;
    logic [4:0] command;
    logic [7:0] rx_buf, heard;
    wire        scl = ~(m_scl_oe | s_scl_oe);
    wire        sda = ~(m_sda_oe | s_sda_oe);
    int         n_errors = 0;
    int         samples_checked = 0;
    // Ops: 0 transmit, 1 receive, 2 acknowledge, 3 stop, 4 repeated start
    logic [4:0] codes [5] = '{5'h00, 5'h08, 5'h10, 5'h04, 5'h02};
    op_row_s    rows [10] = '{
        '{3'h0, 8'hf4, 1'h0, 1'h0, 1'h0},
        '{3'h0, 8'h5a, 1'h0, 1'h0, 1'h0},
        '{3'h4, 8'h00, 1'h0, 1'h0, 1'h0},
        '{3'h0, 8'hf5, 1'h0, 1'h0, 1'h0},
        '{3'h1, 8'ha5, 1'h0, 1'h0, 1'h1},
        '{3'h2, 8'h00, 1'h0, 1'h0, 1'h0},
        '{3'h1, 8'h3c, 1'h0, 1'h0, 1'h0},
        '{3'h2, 8'h00, 1'h0, 1'h1, 1'h0},
        '{3'h0, 8'h81, 1'h1, 1'h0, 1'h0},
        '{3'h3, 8'h00, 1'h0, 1'h0, 1'h0}
    };

    always #4 i_clock = ~i_clock;

    i2c_master_byte_engine u_i2c_master_byte_engine (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_baud_reload(9'h003),
        .i_tx_write(tx_write), .i_tx_data(tx_data), .i_cmd_write(cmd_write),
        .i_cmd_bits(cmd_bits), .i_ack_data_select(ack_sel), .i_rx_read(rx_read),
        .i_collision_clear(coll_clr), .i_overflow_clear(ovf_clr), .i_scl(scl), .i_sda(sda),
        .o_scl_out(scl_out), .o_scl_oe(m_scl_oe), .o_sda_out(sda_out), .o_sda_oe(m_sda_oe),
        .o_command(command), .o_tx_buffer_full(tx_buffer_full), .o_ack_received_status(ack_st),
        .o_write_collision_flag(coll), .o_receive_buffer_reg(rx_buf), .o_rx_buffer_full(rx_buffer_full),
        .o_receive_overflow_flag(ovf), .o_start_seen(start_seen), .o_stop_seen(stop_seen),
        .o_master_event_irq(irq));

    i2c_slave_model u_i2c_slave_model (
        .i_scl(scl), .i_sda(sda), .i_mode(mode), .i_frame_start(frame_start),
        .i_ack_n(s_ack_n), .i_talk_byte(talk), .i_stretch(stretch), .o_scl_oe(s_scl_oe),
        .o_sda_oe(s_sda_oe), .o_heard_byte(heard), .o_last_bit(last_bit));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (!ok)
        begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check

    task automatic step();
        @(posedge i_clock);
        #1;
    endtask : step

    task automatic wait_irq();
        int n;
        for (n = 0; n < 3000; n++)
        begin
            step();
            if (irq === 1'b1)
                break;
        end
        if (n == 3000)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask : wait_irq

    // Which: 0 buffer read, 1 collision clear, 2 overflow clear
    task automatic pulse(input int which);
        step();
        rx_read  = (which == 0);
        coll_clr = (which == 1);
        ovf_clr  = (which == 2);
        step();
        {rx_read, coll_clr, ovf_clr} = 3'h0;
    endtask : pulse

    // Inject: 1 transmit write while busy, 2 command write while busy
    task automatic run_op(input op_row_s r, input logic [1:0] inject);
        step();
        mode        = (r.op == 3'h0) ? 2'h1 : (r.op == 3'h1) ? 2'h2 : 2'h0;
        s_ack_n     = r.ack_n;
        talk        = r.data;
        stretch     = r.stretch;
        ack_sel     = r.ack_sel;
        frame_start = 1'b1;
        step();
        frame_start = 1'b0;
        tx_write    = (r.op == 3'h0);
        tx_data     = r.data;
        cmd_write   = (r.op != 3'h0);
        cmd_bits    = codes[r.op];
        step();
        tx_write  = 1'b0;
        cmd_write = 1'b0;
        if (r.op == 3'h0)
            check(tx_buffer_full === 1'b1, "buffer full not set");
        if (inject != 2'h0)
        begin
            repeat (20) @(posedge i_clock);
            #1;
            tx_write  = (inject == 2'h1);
            tx_data   = 8'hff;
            cmd_write = (inject == 2'h2);
            cmd_bits  = 5'h04;
            step();
            tx_write  = 1'b0;
            cmd_write = 1'b0;
            check(command === 5'h00, "command taken while busy");
        end
        wait_irq();
        check(command === 5'h00, "command not cleared");
    endtask : run_op

    initial
    begin
        repeat (3) @(posedge i_clock);
        #1;
        i_reset_n = 1'b1;
        check({command, tx_buffer_full, ack_st, coll, rx_buf, rx_buffer_full, ovf, start_seen, stop_seen, irq,
               m_scl_oe, m_sda_oe, scl_out, sda_out} === '0, "reset values");
        for (int i = 0; i < 10; i++)
        begin
            run_op(rows[i], 2'h0);
            case (rows[i].op)
                3'h0: check(ack_st === rows[i].ack_n && heard === rows[i].data && tx_buffer_full === 1'b0,
                            "transmit");
                3'h1: check(rx_buf === rows[i].data && rx_buffer_full === 1'b1, "receive");
                3'h2: check(last_bit === rows[i].ack_sel, "ack polarity");
                3'h3: check(stop_seen === 1'b1 && start_seen === 1'b0, "stop");
                default: check(start_seen === 1'b1 && stop_seen === 1'b0 && m_scl_oe === 1'b1,
                               "restart");
            endcase
            if (rows[i].op == 3'h1)
            begin
                pulse(0);
                check(rx_buffer_full === 1'b0, "buffer full not cleared");
            end
        end
        run_op(op_row_s'{3'h0, 8'hc3, 1'h0, 1'h0, 1'h0}, 2'h1);
        check(coll === 1'b1 && heard === 8'hc3, "collision");
        run_op(op_row_s'{3'h0, 8'h96, 1'h0, 1'h0, 1'h0}, 2'h2);
        check(coll === 1'b1 && heard === 8'h96, "collision flag lost");
        pulse(1);
        check(coll === 1'b0, "collision not cleared");
        run_op(op_row_s'{3'h1, 8'h11, 1'h0, 1'h0, 1'h0}, 2'h0);
        run_op(op_row_s'{3'h1, 8'h22, 1'h0, 1'h0, 1'h0}, 2'h0);
        check(ovf === 1'b1 && rx_buf === 8'h11, "overflow");
        pulse(0);
        run_op(op_row_s'{3'h1, 8'h33, 1'h0, 1'h0, 1'h0}, 2'h0);
        check(rx_buf === 8'h33 && ovf === 1'b1, "after overflow");
        pulse(2);
        check(ovf === 1'b0, "overflow not cleared");
        report_and_stop();
    end
endmodule : tb_top
